// ### bench/crm_core_regs_asserts.sv
// property checker for the core register set ports
module crm_core_regs_asserts (
    input wire logic        clk_in,         // clock
    input wire logic        reset_n_in,     // reset
    input wire logic        ready_out,      // boot done
    input wire logic        rd_en_in,       // read request
    input wire logic        rd_valid_out,   // read answer
    input wire logic        vec_valid_in,   // vector word
    input wire logic [31:0] vec_addr_out,   // vector address
    input wire logic        handler_out,    // handler mode
    input wire logic        psp_active_out, // process stack
    input wire logic        stk_wr_out,     // store strobe
    input wire logic        stk_rd_out,     // load strobe
    input wire logic [31:0] stk_addr_out,   // stack address
    input wire logic        sreg_wr_in,     // status write
    input wire logic        sreg_valid_out, // status answer
    input wire logic [31:0] sreg_rdata_out, // status data
    input wire logic        exc_entry_in,   // entry
    input wire logic        exc_ret_in,     // return
    input wire logic [5:0]  exc_num_in,     // entry number
    input wire logic [5:0]  exc_num_out     // current number
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    rd_answer_a: assert property (rd_en_in && ready_out |=> rd_valid_out)
        else $error("read not answered");
    boot_second_a: assert property (vec_valid_in && !ready_out && vec_addr_out == crm_pkg::VEC_STACK_ADDR |=> vec_addr_out == crm_pkg::VEC_RESET_ADDR)
        else $error("second vector address wrong");
    boot_done_a: assert property (vec_valid_in && !ready_out && vec_addr_out == crm_pkg::VEC_RESET_ADDR |=> ready_out)
        else $error("boot not done after vector");
    thread_start_a: assert property ($rose(ready_out) |-> !handler_out)
        else $error("boot left in handler mode");
    handler_main_a: assert property (handler_out |-> !psp_active_out)
        else $error("process stack in handler mode");
    push_desc_a: assert property (stk_wr_out && $past(stk_wr_out) && $stable(psp_active_out) && $stable(handler_out) |-> stk_addr_out == $past(stk_addr_out) - 32'h4)
        else $error("push not descending by a word");
    pop_top_a: assert property (stk_rd_out && $past(stk_wr_out) && $stable(psp_active_out) && $stable(handler_out) |-> stk_addr_out == $past(stk_addr_out))
        else $error("pop not at last pushed item");
    state_zero_a: assert property (sreg_valid_out |-> !sreg_rdata_out[24])
        else $error("state bit read as one");
    num_hold_a: assert property ($past(sreg_wr_in, 2) && !$past(exc_entry_in, 2) && !$past(exc_ret_in, 2) |-> $stable(exc_num_out))
        else $error("status write changed number");
    entry_num_a: assert property (exc_entry_in && ready_out ##1 !exc_ret_in && !exc_entry_in |=> handler_out && exc_num_out == $past(exc_num_in, 2))
        else $error("entry number or mode wrong");
    cover property (exc_entry_in && ready_out);
    cover property (stk_rd_out);
    cover property (sreg_valid_out);
endmodule // crm_core_regs_asserts

// ### bench/crm_core_regs_tb_top.sv
// self-checking bench for the core register set
module crm_core_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] SP0 = 32'h2000_0100;
    localparam logic [31:0] PC0 = 32'h0000_0201;
    localparam logic [31:0] PV = 32'h3000_0000;
    logic clk_in, reset_n_in, vec_req_out, vec_valid_in, ready_out, rd_en_in;
    logic rd_valid_out, wr_en_in, flags_we_in, sreg_rd_in, sreg_wr_in;
    logic sreg_valid_out, tbit_we_in, tbit_in, push_in, pop_in, stk_wr_out;
    logic stk_rd_out, exc_entry_in, exc_ret_in, exc_ret_psp_in, exc_ret_t_in;
    logic exec_in, fault_out, handler_out, psp_active_out, tbit_out;
    logic [31:0] vec_addr_out, vec_data_in, rd_data_out, wr_data_in, pc_out;
    logic [31:0] sreg_wdata_in, sreg_rdata_out, push_data_in, stk_addr_out;
    logic [31:0] stk_data_out, exc_vec_in;
    logic [3:0]  rd_idx_in, wr_idx_in, flags_in, flags_out;
    logic [5:0]  exc_num_in, exc_ret_num_in, exc_num_out;
    crm_pkg::crm_sreg_t sreg_sel_in;
    int bad_count, n_checks, cycles;
    crm_core_regs uut (.*);
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] i, input logic [31:0] e);
        rd_en_in <= 1'b1;
        rd_idx_in <= i;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        @(posedge clk_in);
        chk(rd_data_out, e);
    endtask
    task automatic srw(input logic w, input crm_pkg::crm_sreg_t s,
                       input logic [31:0] d);
        sreg_rd_in <= !w;
        sreg_wr_in <= w;
        sreg_sel_in <= s;
        sreg_wdata_in <= d;
        @(posedge clk_in);
        {sreg_rd_in, sreg_wr_in} <= 2'h0;
        @(posedge clk_in);
        if (!w) chk(sreg_rdata_out, d);
    endtask
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        {reset_n_in, vec_valid_in, rd_en_in, wr_en_in, flags_we_in, sreg_rd_in,
         sreg_wr_in, tbit_we_in, tbit_in, push_in, pop_in, exc_entry_in,
         exc_ret_in, exc_ret_psp_in, exec_in, vec_data_in, wr_data_in,
         sreg_wdata_in, push_data_in, exc_vec_in, rd_idx_in, wr_idx_in,
         flags_in, exc_num_in, exc_ret_num_in} = '0;
        {exc_ret_t_in, cycles, bad_count, n_checks} = '0;
        sreg_sel_in = crm_pkg::SREG_FLAGS;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        {vec_valid_in, vec_data_in} <= {1'b1, SP0};
        @(posedge clk_in);
        vec_valid_in <= 1'b0;
        @(posedge clk_in);
        {vec_valid_in, vec_data_in} <= {1'b1, PC0};
        @(posedge clk_in);
        vec_valid_in <= 1'b0;
        while (ready_out !== 1'b1) @(posedge clk_in);
        rd(crm_pkg::IDX_STACK, SP0);
        rd(crm_pkg::IDX_PROG, PC0);
        chk(tbit_out, 1);
        chk(handler_out, 0);
        {push_in, push_data_in} <= {1'b1, 32'h0000_00A5};
        @(posedge clk_in);
        push_data_in <= 32'h0000_005A;
        @(posedge clk_in);
        {push_in, pop_in} <= 2'h1;
        chk(stk_addr_out, SP0 - 32'h4);
        @(posedge clk_in);
        pop_in <= 1'b0;
        chk(stk_addr_out, SP0 - 32'h8);
        chk(stk_data_out, 32'h0000_005A);
        rd(crm_pkg::IDX_STACK, SP0 - 32'h4);
        srw(1, crm_pkg::SREG_STACK_SEL, 32'h2);
        {wr_en_in, wr_idx_in, wr_data_in} <= {1'b1, crm_pkg::IDX_STACK, PV};
        @(posedge clk_in);
        wr_idx_in <= 4'h3;
        @(posedge clk_in);
        wr_idx_in <= crm_pkg::IDX_LINK;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        rd(crm_pkg::IDX_STACK, PV);
        rd(4'h3, PV);
        rd(crm_pkg::IDX_LINK, PV);
        chk(psp_active_out, 1);
        srw(1, crm_pkg::SREG_STACK_SEL, 32'h0);
        rd(crm_pkg::IDX_STACK, SP0 - 32'h4);
        {flags_we_in, flags_in} <= 5'h1A;
        @(posedge clk_in);
        flags_we_in <= 1'b0;
        srw(0, crm_pkg::SREG_FLAGS, 32'hA000_0000);
        chk(flags_out, 4'hA);
        srw(1, crm_pkg::SREG_ALL, 32'hFFFF_FFFF);
        srw(0, crm_pkg::SREG_ALL, 32'hF000_0000);
        srw(1, crm_pkg::SREG_STACK_SEL, 32'h2);
        {exc_entry_in, exc_num_in, exc_vec_in} <= {7'h50, 32'h0000_0401};
        @(posedge clk_in);
        exc_entry_in <= 1'b0;
        srw(0, crm_pkg::SREG_STACK_SEL, 32'h0);
        srw(0, crm_pkg::SREG_NUMBER, 32'h10);
        rd(crm_pkg::IDX_STACK, SP0 - 32'h4);
        chk(handler_out, 1);
        srw(1, crm_pkg::SREG_FLAGS_NUMBER, 32'h0);
        srw(0, crm_pkg::SREG_FLAGS_NUMBER, 32'h10);
        {exc_ret_in, exc_ret_psp_in} <= 2'h3;
        @(posedge clk_in);
        exc_ret_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk(handler_out, 0);
        exec_in <= 1'b1;
        rd(crm_pkg::IDX_STACK, PV);
        chk(fault_out, 1);
        conclude();
    end
endmodule // crm_core_regs_tb_top

bind crm_core_regs crm_core_regs_asserts u_chk (.*);

// ### src/crm_core_regs.sv
// core register set, operating mode and stack pointer selection
module crm_core_regs (
    input  wire logic          clk_in,          // processor clock
    input  wire logic          reset_n_in,      // async reset, active low
    // reset vector fetch
    output logic               vec_req_out,     // vector fetch request
    output logic      [31:0]   vec_addr_out,    // vector address
    input  wire logic          vec_valid_in,    // vector word returned
    input  wire logic [31:0]   vec_data_in,     // vector word
    output logic               ready_out,       // boot done
    // register port
    input  wire logic          rd_en_in,        // read register
    input  wire logic [3:0]    rd_idx_in,       // read index
    output logic      [31:0]   rd_data_out,     // read data
    output logic               rd_valid_out,    // read data valid
    input  wire logic          wr_en_in,        // write register
    input  wire logic [3:0]    wr_idx_in,       // write index
    input  wire logic [31:0]   wr_data_in,      // write data
    // condition flags from execution
    input  wire logic          flags_we_in,     // update flags
    input  wire logic [3:0]    flags_in,        // new N Z C V
    // status moves
    input  wire logic          sreg_rd_in,      // move from status
    input  wire logic          sreg_wr_in,      // move to status
    input  crm_pkg::crm_sreg_t sreg_sel_in,     // status name
    input  wire logic [31:0]   sreg_wdata_in,   // move to status data
    output logic      [31:0]   sreg_rdata_out,  // move from status data
    output logic               sreg_valid_out,  // status data valid
    // state bit from branch-exchange style instructions
    input  wire logic          tbit_we_in,      // write state bit
    input  wire logic          tbit_in,         // new state bit
    // stack
    input  wire logic          push_in,         // push item
    input  wire logic [31:0]   push_data_in,    // item to push
    input  wire logic          pop_in,          // pop item
    output logic               stk_wr_out,      // stack store strobe
    output logic               stk_rd_out,      // stack load strobe
    output logic      [31:0]   stk_addr_out,    // stack address
    output logic      [31:0]   stk_data_out,    // stack store data
    // exceptions
    input  wire logic          exc_entry_in,    // exception taken
    input  wire logic [5:0]    exc_num_in,      // its number
    input  wire logic [31:0]   exc_vec_in,      // its vector word
    input  wire logic          exc_ret_in,      // exception return
    input  wire logic [5:0]    exc_ret_num_in,  // number resumed, 0 thread
    input  wire logic          exc_ret_psp_in,  // thread resumes on psp
    input  wire logic          exc_ret_t_in,    // restored state bit
    input  wire logic          exec_in,         // instruction issued
    output logic               fault_out,       // state bit fault pulse
    // state
    output logic               handler_out,     // handler mode
    output logic               psp_active_out,  // process stack in use
    output logic               tbit_out,        // execution state bit
    output logic      [3:0]    flags_out,       // N Z C V
    output logic      [5:0]    exc_num_out,     // current exception
    output logic      [31:0]   pc_out           // program address
);

    crm_pkg::crm_boot_t boot_q;
    logic [31:0] gpr_q [crm_pkg::DATA_REG_COUNT];
    logic [31:0] link_q;
    logic [31:0] pc_q;
    logic [3:0]  flags_q;
    logic [5:0]  exc_num_q;
    logic        handler_q;
    logic        sel_bit_q;
    logic        tbit_q;
    logic        run;
    logic        sel_psp;
    logic        sp_wr;
    logic        boot_ld;
    logic [31:0] sp_val;
    logic [31:0] view_rd;
    logic        view_wr_flags;
    logic        view_wr_sel;

    function automatic logic is_data_idx(input logic [3:0] idx);
        return idx <= crm_pkg::IDX_LAST_DATA;
    endfunction

    assign run     = (boot_q == crm_pkg::BOOT_RUN);
    assign sel_psp = sel_bit_q & ~handler_q;
    assign sp_wr   = run & wr_en_in & (wr_idx_in == crm_pkg::IDX_STACK);
    assign boot_ld = (boot_q == crm_pkg::BOOT_STACK) & vec_valid_in;

    // ------------------------------------------------------------
    // reset vector fetch
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            boot_q <= crm_pkg::BOOT_STACK;
        end else begin
            unique case (boot_q)
                crm_pkg::BOOT_STACK: begin
                    if (vec_valid_in) begin
                        boot_q <= crm_pkg::BOOT_PROG;
                    end
                end
                crm_pkg::BOOT_PROG: begin
                    if (vec_valid_in) begin
                        boot_q <= crm_pkg::BOOT_RUN;
                    end
                end
                crm_pkg::BOOT_RUN: begin
                    boot_q <= crm_pkg::BOOT_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            vec_req_out  <= 1'b1;
            vec_addr_out <= crm_pkg::VEC_STACK_ADDR;
            ready_out    <= 1'b0;
        end else if (vec_valid_in && boot_q == crm_pkg::BOOT_STACK) begin
            vec_addr_out <= crm_pkg::VEC_RESET_ADDR;
        end else if (vec_valid_in && boot_q == crm_pkg::BOOT_PROG) begin
            vec_req_out  <= 1'b0;
            vec_addr_out <= crm_pkg::WORD_RESET;
            ready_out    <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // stack pointer copies
    // ------------------------------------------------------------
    crm_stack_bank u_stack (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .sel_psp_in  (sel_psp),
        .boot_ld_in  (boot_ld),
        .boot_val_in (vec_data_in),
        .wr_en_in    (sp_wr),
        .wr_val_in   (wr_data_in),
        .push_in     (run & push_in),
        .pop_in      (run & pop_in),
        .active_out  (sp_val)
    );

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stk_wr_out   <= 1'b0;
            stk_rd_out   <= 1'b0;
            stk_addr_out <= crm_pkg::WORD_RESET;
            stk_data_out <= crm_pkg::WORD_RESET;
        end else begin
            stk_wr_out <= run & push_in;
            stk_rd_out <= run & ~push_in & pop_in;
            if (run && push_in) begin
                stk_addr_out <= sp_val - crm_pkg::STACK_STEP;
                stk_data_out <= push_data_in;
            end else if (run && pop_in) begin
                stk_addr_out <= sp_val;
            end
        end
    end

    // ------------------------------------------------------------
    // data and link registers, no reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (run && wr_en_in && is_data_idx(wr_idx_in)) begin
            gpr_q[wr_idx_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (run && wr_en_in && wr_idx_in == crm_pkg::IDX_LINK) begin
            link_q <= wr_data_in;
        end
    end

    // ------------------------------------------------------------
    // program address
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pc_q <= crm_pkg::WORD_RESET;
        end else if (boot_q == crm_pkg::BOOT_PROG && vec_valid_in) begin
            pc_q <= vec_data_in;
        end else if (run && exc_entry_in) begin
            pc_q <= exc_vec_in;
        end else if (run && wr_en_in && wr_idx_in == crm_pkg::IDX_PROG) begin
            pc_q <= wr_data_in;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= crm_pkg::WORD_RESET;
        end else begin
            rd_valid_out <= run & rd_en_in;
            if (run && rd_en_in) begin
                if (is_data_idx(rd_idx_in)) begin
                    rd_data_out <= gpr_q[rd_idx_in];
                end else if (rd_idx_in == crm_pkg::IDX_STACK) begin
                    rd_data_out <= sp_val;
                end else if (rd_idx_in == crm_pkg::IDX_LINK) begin
                    rd_data_out <= link_q;
                end else begin
                    rd_data_out <= pc_q;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // mode and exception number
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            exc_num_q <= crm_pkg::EXC_NUM_RESET;
            handler_q <= 1'b0;
        end else if (run && exc_entry_in) begin
            exc_num_q <= exc_num_in;
            handler_q <= 1'b1;
        end else if (run && exc_ret_in) begin
            exc_num_q <= exc_ret_num_in;
            handler_q <= (exc_ret_num_in != crm_pkg::EXC_NUM_RESET);
        end
    end

    // ------------------------------------------------------------
    // status views
    // ------------------------------------------------------------
    crm_status_view u_view (
        .sel_in       (sreg_sel_in),
        .flags_in     (flags_q),
        .exc_num_in   (exc_num_q),
        .stack_sel_in (sel_psp),
        .rd_val_out   (view_rd),
        .wr_flags_out (view_wr_flags),
        .wr_sel_out   (view_wr_sel)
    );

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_q <= crm_pkg::FLAGS_RESET;
        end else if (run && sreg_wr_in && view_wr_flags) begin
            flags_q <= sreg_wdata_in[crm_pkg::FLAG_N_BIT:crm_pkg::FLAG_V_BIT];
        end else if (run && flags_we_in) begin
            flags_q <= flags_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sel_bit_q <= crm_pkg::STACK_SEL_RESET;
        end else if (run && exc_ret_in && !exc_entry_in
                     && exc_ret_num_in == crm_pkg::EXC_NUM_RESET) begin
            sel_bit_q <= exc_ret_psp_in;
        end else if (run && sreg_wr_in && view_wr_sel && !handler_q) begin
            sel_bit_q <= sreg_wdata_in[crm_pkg::STACK_SEL_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sreg_valid_out <= 1'b0;
            sreg_rdata_out <= crm_pkg::WORD_RESET;
        end else begin
            sreg_valid_out <= run & sreg_rd_in;
            if (run && sreg_rd_in) begin
                sreg_rdata_out <= view_rd;
            end
        end
    end

    // ------------------------------------------------------------
    // execution state bit and its fault
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tbit_q <= 1'b0;
        end else if (boot_q == crm_pkg::BOOT_PROG && vec_valid_in) begin
            tbit_q <= vec_data_in[crm_pkg::VEC_T_BIT];
        end else if (run && exc_entry_in) begin
            tbit_q <= exc_vec_in[crm_pkg::VEC_T_BIT];
        end else if (run && exc_ret_in) begin
            tbit_q <= exc_ret_t_in;
        end else if (run && tbit_we_in) begin
            tbit_q <= tbit_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_out <= 1'b0;
        end else begin
            fault_out <= run & exec_in & ~tbit_q;
        end
    end

    // ------------------------------------------------------------
    // state outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            handler_out    <= 1'b0;
            psp_active_out <= 1'b0;
            tbit_out       <= 1'b0;
            flags_out      <= crm_pkg::FLAGS_RESET;
            exc_num_out    <= crm_pkg::EXC_NUM_RESET;
            pc_out         <= crm_pkg::WORD_RESET;
        end else begin
            handler_out    <= handler_q;
            psp_active_out <= sel_psp;
            tbit_out       <= tbit_q;
            flags_out      <= flags_q;
            exc_num_out    <= exc_num_q;
            pc_out         <= pc_q;
        end
    end

endmodule // crm_core_regs

// ### src/crm_pkg.sv
// constants and types shared by the core register set
package crm_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [3:0]  IDX_LAST_DATA   = 4'hC;
    localparam logic [3:0]  IDX_STACK       = 4'hD;
    localparam logic [3:0]  IDX_LINK        = 4'hE;
    localparam logic [3:0]  IDX_PROG        = 4'hF;
    localparam int          DATA_REG_COUNT  = 13;

    // ------------------------------------------------------------
    // reset vector addresses
    // ------------------------------------------------------------
    localparam logic [31:0] VEC_STACK_ADDR  = 32'h0000_0000;
    localparam logic [31:0] VEC_RESET_ADDR  = 32'h0000_0004;

    // ------------------------------------------------------------
    // status register field positions
    // ------------------------------------------------------------
    localparam int          FLAG_N_BIT      = 31;
    localparam int          FLAG_V_BIT      = 28;
    localparam int          STATE_T_BIT     = 24;
    localparam int          EXC_NUM_MSB     = 5;
    localparam int          VEC_T_BIT       = 0;
    localparam int          STACK_SEL_BIT   = 1;

    // ------------------------------------------------------------
    // reset values and steps
    // ------------------------------------------------------------
    localparam logic [5:0]  EXC_NUM_RESET   = 6'h00;
    localparam logic        STACK_SEL_RESET = 1'b0;
    localparam logic [3:0]  FLAGS_RESET     = 4'h0;
    localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
    localparam logic [31:0] STACK_STEP      = 32'h0000_0004;

    // ------------------------------------------------------------
    // status move names
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SREG_FLAGS,
        SREG_NUMBER,
        SREG_STATE,
        SREG_STATE_NUMBER,
        SREG_FLAGS_NUMBER,
        SREG_FLAGS_STATE,
        SREG_ALL,
        SREG_STACK_SEL
    } crm_sreg_t;

    // ------------------------------------------------------------
    // reset vector fetch sequence
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BOOT_STACK,
        BOOT_PROG,
        BOOT_RUN
    } crm_boot_t;

endpackage

// ### src/crm_stack_bank.sv
// the two stack pointer copies and their update logic
module crm_stack_bank (
    input  wire logic        clk_in,        // processor clock
    input  wire logic        reset_n_in,    // async reset, active low
    input  wire logic        sel_psp_in,    // process copy is active
    input  wire logic        boot_ld_in,    // load main copy at boot
    input  wire logic [31:0] boot_val_in,   // value for boot load
    input  wire logic        wr_en_in,      // write active copy
    input  wire logic [31:0] wr_val_in,     // write value
    input  wire logic        push_in,       // decrement active copy
    input  wire logic        pop_in,        // increment active copy
    output logic      [31:0] active_out     // active copy value
);

    logic [31:0] msp_q;
    logic [31:0] psp_q;
    logic [31:0] next_val;

    // ------------------------------------------------------------
    // next value of the selected copy
    // ------------------------------------------------------------
    always_comb begin
        next_val = active_out;
        if (push_in) begin
            next_val = active_out - crm_pkg::STACK_STEP;
        end else if (pop_in) begin
            next_val = active_out + crm_pkg::STACK_STEP;
        end else if (wr_en_in) begin
            next_val = wr_val_in;
        end
    end

    assign active_out = sel_psp_in ? psp_q : msp_q;

    // ------------------------------------------------------------
    // main copy
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            msp_q <= crm_pkg::WORD_RESET;
        end else if (boot_ld_in) begin
            msp_q <= boot_val_in;
        end else if (!sel_psp_in) begin
            msp_q <= next_val;
        end
    end

    // ------------------------------------------------------------
    // process copy, undefined after reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sel_psp_in) begin
            psp_q <= next_val;
        end
    end

endmodule // crm_stack_bank

// ### src/crm_status_view.sv
// status move read value and write permission per name
module crm_status_view (
    input  crm_pkg::crm_sreg_t sel_in,        // status name selected
    input  wire logic [3:0]    flags_in,      // condition flags
    input  wire logic [5:0]    exc_num_in,    // current exception
    input  wire logic          stack_sel_in,  // stack select as read
    output logic      [31:0]   rd_val_out,    // value seen by a read
    output logic               wr_flags_out,  // write reaches flags
    output logic               wr_sel_out     // write reaches select
);

    logic [31:0] flag_word;
    logic [31:0] num_word;

    always_comb begin
        flag_word = crm_pkg::WORD_RESET;
        flag_word[crm_pkg::FLAG_N_BIT:crm_pkg::FLAG_V_BIT] = flags_in;
        num_word  = crm_pkg::WORD_RESET;
        num_word[crm_pkg::EXC_NUM_MSB:0] = exc_num_in;
        rd_val_out   = crm_pkg::WORD_RESET;
        wr_flags_out = 1'b0;
        wr_sel_out   = 1'b0;
        // state bits never appear in a read
        unique case (sel_in)
            crm_pkg::SREG_FLAGS: begin
                rd_val_out   = flag_word;
                wr_flags_out = 1'b1;
            end
            crm_pkg::SREG_NUMBER: begin
                rd_val_out = num_word;
            end
            crm_pkg::SREG_STATE: begin
                rd_val_out = crm_pkg::WORD_RESET;
            end
            crm_pkg::SREG_STATE_NUMBER: begin
                rd_val_out = num_word;
            end
            crm_pkg::SREG_FLAGS_NUMBER: begin
                rd_val_out   = flag_word | num_word;
                wr_flags_out = 1'b1;
            end
            crm_pkg::SREG_FLAGS_STATE: begin
                rd_val_out   = flag_word;
                wr_flags_out = 1'b1;
            end
            crm_pkg::SREG_ALL: begin
                rd_val_out   = flag_word | num_word;
                wr_flags_out = 1'b1;
            end
            crm_pkg::SREG_STACK_SEL: begin
                rd_val_out[crm_pkg::STACK_SEL_BIT] = stack_sel_in;
                wr_sel_out = 1'b1;
            end
        endcase
    end

endmodule // crm_status_view
